// [rtl/acrb_pkg.sv]
// Purpose: constants for the converter configuration register bank
// Assumes: 8-bit registers, 8-bit register addresses
// Notes:   offsets, field positions and reset values live here only
package acrb_pkg;
    // register offsets
    localparam logic [7:0] OFS_PORT_CFG   = 8'h00;
    localparam logic [7:0] OFS_PART_ID    = 8'h01;
    localparam logic [7:0] OFS_SPEED      = 8'h02;
    localparam logic [7:0] OFS_CHAN_SEL   = 8'h05;
    localparam logic [7:0] OFS_PWR_MODE   = 8'h08;
    localparam logic [7:0] OFS_CLK_STAB   = 8'h09;
    localparam logic [7:0] OFS_PLL_STAT   = 8'h0a;
    localparam logic [7:0] OFS_CLK_DIV    = 8'h0b;
    localparam logic [7:0] OFS_COMMIT     = 8'hff;
    localparam logic [7:0] OFS_SHADOW_LO  = 8'h08;
    localparam logic [7:0] OFS_SHADOW_HI  = 8'h79;
    // reset values
    localparam logic [7:0] RST_PORT_CFG   = 8'h18;
    localparam logic [7:0] RST_CHAN_SEL   = 8'h03;
    localparam logic [7:0] RST_PWR_MODE   = 8'h00;
    localparam logic [7:0] RST_CLK_STAB   = 8'h01;
    localparam logic [7:0] RST_CLK_DIV    = 8'h00;
    // identity values, arbitrary
    localparam logic [7:0] PART_ID_VAL    = 8'h5a;
    localparam logic [1:0] SPEED_SLOW     = 2'h0;
    localparam logic [1:0] SPEED_FAST     = 2'h2;
    // field positions
    localparam int PC_LSB_HI   = 6;
    localparam int PC_RST_HI   = 5;
    localparam int PC_RST_LO   = 2;
    localparam int PC_LSB_LO   = 1;
    localparam logic [7:0] PC_FIXED = 8'h18;
    localparam int SG_LO       = 4;
    localparam int PM_PIN_FN   = 5;
    localparam int PLL_LOCK_B  = 7;
    localparam int DIV_PH_LO   = 3;
    // power modes
    localparam logic [1:0] PM_NORMAL  = 2'h0;
    localparam logic [1:0] PM_OFF     = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;
endpackage : acrb_pkg

// [rtl/acrb_chan.sv]
// Purpose: one channel's local power-mode register, staged and active copy
// Assumes: write strobe already gated by channel select
// Notes:   active copy moves only on commit
`timescale 1ns/1ns
module acrb_chan
    import acrb_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // staging and commit
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       commit,
    // copies
    output logic      [7:0] staged,
    output logic      [7:0] active
);
    logic [7:0] staged_r, staged_nxt;
    logic [7:0] active_r, active_nxt;

    // staging write and synchronous commit
    always_comb begin
        staged_nxt = staged_r;
        active_nxt = active_r;
        if (wr_en) begin
            staged_nxt = wr_data & 8'h23;  // unsupported bits stay zero
        end
        if (commit) begin
            active_nxt = staged_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            staged_r <= RST_PWR_MODE;
            active_r <= RST_PWR_MODE;
        end else if (clk_en) begin
            staged_r <= staged_nxt;
            active_r <= active_nxt;
        end
    end

    assign staged = staged_r;
    assign active = active_r;
endmodule // acrb_chan

// [rtl/acrb_bank.sv]
// Function
// - addresses and bits outside the map read zero and ignore writes.
// - port config mirrors shift-order at 6/1 and soft reset at 5/2, bits 4:3 one, default 0x18.
// - speed grade reads in bits 5:4, 00 slow grade, 10 fast grade.
// - channel select bit 1 picks B, bit 0 picks A, both default set.
// - with both selected a write updates both channels and a read returns A.
// - commit bit 0 copies staged settings into active ones together.
// - writes to 0x08..0x79 are staged only and the commit bit clears itself.
// - power mode bits 1:0 per channel: normal, off, standby, reserved.
// - power mode bit 5 picks off or standby for the power-down pin.
// - divide code n divides by n+1, default 000.
// - divider phase bits 5:3 delay by 0..7 input cycles.
// - stabilizer enable defaults one and is forced on by nonzero divide.
//
// Purpose: register bank with simple parallel access port
// Assumes: serial framing is decoded outside; one access per strobe
// Notes:   read data registered one cycle after rd_en
`timescale 1ns/1ns
module acrb_bank
    import acrb_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // register access
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    // device status
    input  wire logic       fast_grade,
    input  wire logic       pll_locked,
    input  wire logic       pdwn_pin,
    // active settings
    output logic      [1:0] mode_a,
    output logic      [1:0] mode_b,
    output logic            dcs_on,
    output logic      [2:0] div_ratio,
    output logic      [2:0] div_phase,
    output logic            lsb_first,
    output logic            soft_reset
);
    ////////////////////////////////////////////////////////////////
    // state
    logic [7:0] port_cfg_r, port_cfg_nxt;
    logic [1:0] chan_sel_r, chan_sel_nxt;
    logic [7:0] stab_stg_r, stab_stg_nxt, stab_act_r, stab_act_nxt;
    logic [7:0] div_stg_r, div_stg_nxt, div_act_r, div_act_nxt;
    logic       commit_r, commit_nxt;
    logic       pll_r;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic [1:0] mode_a_r, mode_b_r, mode_a_nxt, mode_b_nxt;
    logic       dcs_r, dcs_nxt;
    logic [2:0] ratio_r, ratio_nxt, phase_r, phase_nxt;
    logic [7:0] stg_a, stg_b, act_a, act_b;

    // effective mode: pin overrides register, bit 5 picks off or standby
    function automatic logic [1:0] eff_mode(input logic [7:0] v, input logic pin);
        if (pin) begin
            eff_mode = v[PM_PIN_FN] ? PM_STANDBY : PM_OFF;
        end else begin
            eff_mode = v[1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // per-channel local registers, write gated by channel select
    acrb_chan u_chan_a (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .wr_en    (wr_en && addr == OFS_PWR_MODE && chan_sel_r[0]),
        .wr_data  (wr_data),
        .commit   (commit_r),
        .staged   (stg_a),
        .active   (act_a)
    );
    acrb_chan u_chan_b (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .wr_en    (wr_en && addr == OFS_PWR_MODE && chan_sel_r[1]),
        .wr_data  (wr_data),
        .commit   (commit_r),
        .staged   (stg_b),
        .active   (act_b)
    );

    ////////////////////////////////////////////////////////////////
    // writes; port config is taken whatever the channel selects hold
    always_comb begin
        port_cfg_nxt = port_cfg_r;
        chan_sel_nxt = chan_sel_r;
        stab_stg_nxt = stab_stg_r;
        div_stg_nxt  = div_stg_r;
        stab_act_nxt = stab_act_r;
        div_act_nxt  = div_act_r;
        commit_nxt   = 1'b0;                         // self clearing
        // soft reset is a pulse bit, so it drops after one cycle
        port_cfg_nxt[PC_RST_HI] = 1'b0;
        port_cfg_nxt[PC_RST_LO] = 1'b0;
        if (commit_r) begin
            stab_act_nxt = stab_stg_r;
            div_act_nxt  = div_stg_r;
        end
        if (wr_en) begin
            case (addr)
                OFS_PORT_CFG: begin
                    // accept either nibble so shift order never matters
                    port_cfg_nxt = PC_FIXED;
                    port_cfg_nxt[PC_LSB_HI] = wr_data[PC_LSB_HI] | wr_data[PC_LSB_LO];
                    port_cfg_nxt[PC_LSB_LO] = wr_data[PC_LSB_HI] | wr_data[PC_LSB_LO];
                    port_cfg_nxt[PC_RST_HI] = wr_data[PC_RST_HI] | wr_data[PC_RST_LO];
                    port_cfg_nxt[PC_RST_LO] = wr_data[PC_RST_HI] | wr_data[PC_RST_LO];
                end
                OFS_CHAN_SEL: chan_sel_nxt = wr_data[1:0];
                OFS_CLK_STAB: stab_stg_nxt = {7'h00, wr_data[0]};
                OFS_CLK_DIV:  div_stg_nxt  = {2'h0, wr_data[5:0]};
                OFS_COMMIT:   commit_nxt   = wr_data[0];
                default: ;                                           // ignored
            endcase
        end
    end

    // readback; unmapped reads zero, both-selected reads channel A
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            case (addr)
                OFS_PORT_CFG: rd_data_nxt = port_cfg_r;
                OFS_PART_ID:  rd_data_nxt = PART_ID_VAL;
                OFS_SPEED:    rd_data_nxt = {2'h0, fast_grade ? SPEED_FAST : SPEED_SLOW, 4'h0};
                OFS_CHAN_SEL: rd_data_nxt = {6'h00, chan_sel_r};
                OFS_PWR_MODE: rd_data_nxt = chan_sel_r[0] ? stg_a : stg_b;
                OFS_CLK_STAB: rd_data_nxt = stab_stg_r;
                OFS_PLL_STAT: rd_data_nxt = {pll_r, 7'h00};
                OFS_CLK_DIV:  rd_data_nxt = div_stg_r;
                OFS_COMMIT:   rd_data_nxt = {7'h00, commit_r};
                default:      rd_data_nxt = 8'h00;
            endcase
        end
    end

    // derived outputs registered so each port comes from a flip-flop
    always_comb begin
        mode_a_nxt = eff_mode(act_a, pdwn_pin);
        mode_b_nxt = eff_mode(act_b, pdwn_pin);
        ratio_nxt  = div_act_r[2:0];                                 // divide by n+1
        phase_nxt  = div_act_r[5:DIV_PH_LO];
        dcs_nxt    = stab_act_r[0] | (div_act_r[2:0] != 3'h0);
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_cfg_r <= RST_PORT_CFG;
            chan_sel_r <= RST_CHAN_SEL[1:0];
            stab_stg_r <= RST_CLK_STAB;
            stab_act_r <= RST_CLK_STAB;
            div_stg_r  <= RST_CLK_DIV;
            div_act_r  <= RST_CLK_DIV;
            commit_r   <= 1'b0;
            pll_r      <= 1'b0;
            rd_data_r  <= 8'h00;
            mode_a_r   <= PM_NORMAL;
            mode_b_r   <= PM_NORMAL;
            dcs_r      <= 1'b1;
            ratio_r    <= 3'h0;
            phase_r    <= 3'h0;
        end else if (clk_en) begin
            port_cfg_r <= port_cfg_nxt;
            chan_sel_r <= chan_sel_nxt;
            stab_stg_r <= stab_stg_nxt;
            stab_act_r <= stab_act_nxt;
            div_stg_r  <= div_stg_nxt;
            div_act_r  <= div_act_nxt;
            commit_r   <= commit_nxt;
            pll_r      <= pll_locked;
            rd_data_r  <= rd_data_nxt;
            mode_a_r   <= mode_a_nxt;
            mode_b_r   <= mode_b_nxt;
            dcs_r      <= dcs_nxt;
            ratio_r    <= ratio_nxt;
            phase_r    <= phase_nxt;
        end
    end

    assign rd_data    = rd_data_r;
    assign mode_a     = mode_a_r;
    assign mode_b     = mode_b_r;
    assign dcs_on     = dcs_r;
    assign div_ratio  = ratio_r;
    assign div_phase  = phase_r;
    assign lsb_first  = port_cfg_r[PC_LSB_HI];
    assign soft_reset = port_cfg_r[PC_RST_HI];

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence commit_wr_s;
        clk_en && wr_en && addr == OFS_COMMIT && wr_data[0];
    endsequence

    // a second commit write right behind the first legitimately keeps the bit set
    commit_self_clear_a: assert property (commit_wr_s ##1 clk_en && !(wr_en && addr == OFS_COMMIT)
                                          |=> !commit_r)
        else $error("commit bit did not clear");
    commit_copies_a: assert property (clk_en && commit_r |=> div_act_r == $past(div_stg_r))
        else $error("commit did not copy divider");
    stage_only_a: assert property (clk_en && wr_en && addr == OFS_CLK_DIV && !commit_r
                                   |=> div_act_r == $past(div_act_r))
        else $error("staged write changed active");
    dcs_forced_a: assert property (clk_en && div_act_r[2:0] != 3'h0 |=> dcs_on)
        else $error("stabilizer not forced");
    mirror_cfg_a: assert property (port_cfg_r[PC_LSB_HI] == port_cfg_r[PC_LSB_LO]
                                   && port_cfg_r[PC_RST_HI] == port_cfg_r[PC_RST_LO]
                                   && port_cfg_r[4:3] == 2'h3)
        else $error("port config not mirrored");
    part_id_read_a: assert property (clk_en && rd_en && addr == OFS_PART_ID |=> rd_data == PART_ID_VAL)
        else $error("part code wrong");
    unmapped_zero_a: assert property (clk_en && rd_en && addr == 8'h03 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    pll_read_a: assert property (clk_en ##1 clk_en && rd_en && addr == OFS_PLL_STAT
                                 |=> rd_data[7] == $past(pll_locked, 2))
        else $error("pll lock readback wrong");
    both_write_a: assert property (clk_en && wr_en && addr == OFS_PWR_MODE && chan_sel_r == 2'h3
                                   |=> stg_a == stg_b)
        else $error("both channels not written");
    pin_mode_a: assert property (clk_en && pdwn_pin && act_a[PM_PIN_FN] |=> mode_a == PM_STANDBY)
        else $error("pin standby not applied");
endmodule // acrb_bank

// [dv/acrb_host.sv]
// Purpose: host model that issues single-byte register accesses
// Assumes: requests launched on a falling edge, taken on the next rising edge
// Notes:   a gap of idle cycles lets a test pace the host slowly
`timescale 1ns/1ns
module acrb_host (
    // clock
    input  wire logic       core_clk,
    // access port
    output logic      [7:0] addr,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    ////////////////////////////////////////
    // idle port at time zero
    initial begin
        addr    = 8'h00;
        wr_data = 8'h00;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
    end

    // one strobe, held across exactly one rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(negedge core_clk);
        @(negedge core_clk);
        addr    = a;
        wr_data = d;
        wr_en   = wr;
        rd_en   = !wr;
        @(negedge core_clk);
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        addr    = ~a;  // released lines must not keep the last value
        wr_data = ~d;
    endtask

    // read data stands until the next read, so one extra cycle is safe
    task automatic read(input logic [7:0] a, output logic [7:0] d, input int gap);
        access(1'b0, a, 8'h00, gap);
        @(negedge core_clk);
        d = rd_data;
    endtask
endmodule // acrb_host

// [dv/adc_config_register_bank_test.sv]
// Purpose: self-checking bench for the converter register bank
// Assumes: host model drives the access port on falling edges
// Notes:   expectations come from package constants and fixed patterns
`timescale 1ns/1ns
module adc_config_register_bank_test
    import acrb_pkg::*;
();
    logic       core_clk, rst, clk_en, fast_grade, pll_locked, pdwn_pin;
    logic [7:0] addr, wr_data, rd_data, rv;
    logic       wr_en, rd_en, dcs_on, lsb_first, soft_reset;
    logic [1:0] mode_a, mode_b;
    logic [2:0] div_ratio, div_phase;
    int         n_errors = 0;
    int         tests_run = 0;
    int         n_pulse = 0;
    int         n0;
    logic [7:0] r_ofs [9] = '{OFS_PORT_CFG, OFS_PART_ID, OFS_SPEED, OFS_CHAN_SEL, OFS_PWR_MODE,
                              OFS_CLK_STAB, OFS_PLL_STAT, OFS_CLK_DIV, OFS_COMMIT};
    logic [7:0] r_def [9] = '{RST_PORT_CFG, PART_ID_VAL, 8'h00, RST_CHAN_SEL, RST_PWR_MODE,
                              RST_CLK_STAB, 8'h00, RST_CLK_DIV, 8'h00};
    logic [7:0] ro_ofs [5] = '{OFS_PART_ID, OFS_SPEED, OFS_PLL_STAT, 8'h03, 8'h0c};
    logic [7:0] ro_exp [5] = '{PART_ID_VAL, {2'h0, SPEED_FAST, 4'h0}, 8'h80, 8'h00, 8'h00};

    acrb_bank DUT (.core_clk, .rst, .clk_en, .addr, .wr_en, .rd_en, .wr_data, .rd_data, .fast_grade,
                   .pll_locked, .pdwn_pin, .mode_a, .mode_b, .dcs_on, .div_ratio, .div_phase,
                   .lsb_first, .soft_reset);
    acrb_host host (.core_clk, .addr, .wr_en, .rd_en, .wr_data, .rd_data);

    ////////////////////////////////////////
    // 50 MHz clock, pulse counter for soft reset
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (soft_reset === 1'b1) n_pulse <= n_pulse + 1;

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        host.read(a, rv, 0);
        chk_out(rv, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, 0);
    endtask
    // staged values reach the outputs two cycles after the edge that takes the commit write
    task automatic commit();
        wr(OFS_COMMIT, 8'h01);
        repeat (3) @(negedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        {rst, clk_en, fast_grade, pll_locked, pdwn_pin} = 5'b11000;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) chk_reg(r_ofs[i], r_def[i]);
        chk_out({mode_b, mode_a, dcs_on, lsb_first, soft_reset, 1'b0}, 8'h08);
        chk_out({2'h0, div_phase, div_ratio}, 8'h00);
        $display("test reset done");
        // read-only and unmapped places ignore writes
        fast_grade = 1'b1;
        pll_locked = 1'b1;
        for (int i = 0; i < 5; i++) wr(ro_ofs[i], 8'hff);
        for (int i = 0; i < 5; i++) chk_reg(ro_ofs[i], ro_exp[i]);
        $display("test readonly done");
        // per-channel staging, slow host on the second write
        wr(OFS_CHAN_SEL, 8'h01);
        wr(OFS_PWR_MODE, {6'h0, PM_OFF});
        wr(OFS_CHAN_SEL, 8'h02);
        host.access(1'b1, OFS_PWR_MODE, {6'h0, PM_STANDBY}, 3);
        chk_out({4'h0, mode_b, mode_a}, 8'h00);
        chk_reg(OFS_PWR_MODE, {6'h0, PM_STANDBY});
        commit();
        chk_out({4'h0, mode_b, mode_a}, {4'h0, PM_STANDBY, PM_OFF});
        wr(OFS_CHAN_SEL, RST_CHAN_SEL);
        chk_reg(OFS_PWR_MODE, {6'h0, PM_OFF});
        $display("test channels done");
        // power-down pin function, both channels written at once
        wr(OFS_PWR_MODE, 8'h20);
        commit();
        pdwn_pin = 1'b1;
        repeat (2) @(negedge core_clk);
        chk_out({4'h0, mode_b, mode_a}, {4'h0, PM_STANDBY, PM_STANDBY});
        wr(OFS_PWR_MODE, 8'h00);
        commit();
        chk_out({4'h0, mode_b, mode_a}, {4'h0, PM_OFF, PM_OFF});
        pdwn_pin = 1'b0;
        repeat (2) @(negedge core_clk);
        chk_out({4'h0, mode_b, mode_a}, 8'h00);
        $display("test pin done");
        // divider ratio and phase, stabilizer forced by nonzero ratio
        wr(OFS_CLK_STAB, 8'h00);
        wr(OFS_CLK_DIV, 8'h3a);
        chk_reg(OFS_CLK_DIV, 8'h3a);
        chk_reg(OFS_CLK_STAB, 8'h00);
        chk_out({2'h0, div_phase, div_ratio}, 8'h00);
        commit();
        chk_out({dcs_on, 1'b0, div_phase, div_ratio}, 8'hba);
        chk_reg(OFS_COMMIT, 8'h00);
        wr(OFS_CLK_DIV, 8'h00);
        commit();
        chk_out({7'h0, dcs_on}, 8'h00);
        wr(OFS_CLK_STAB, 8'h01);
        commit();
        chk_out({7'h0, dcs_on}, 8'h01);
        $display("test clock done");
        // frozen clock enable drops a write
        clk_en = 1'b0;
        wr(OFS_CHAN_SEL, 8'h00);
        clk_en = 1'b1;
        chk_reg(OFS_CHAN_SEL, RST_CHAN_SEL);
        $display("test freeze done");
        // port configuration, either nibble alone sets shift order
        wr(OFS_CHAN_SEL, 8'h03);
        wr(OFS_PORT_CFG, 8'h40);
        chk_reg(OFS_PORT_CFG, 8'h5a);
        chk_out({7'h0, lsb_first}, 8'h01);
        wr(OFS_PORT_CFG, 8'h18);
        @(negedge core_clk);
        chk_out({7'h0, lsb_first}, 8'h00);
        wr(OFS_PORT_CFG, 8'h02);
        @(negedge core_clk);
        chk_out({7'h0, lsb_first}, 8'h01);
        n0 = n_pulse;
        wr(OFS_PORT_CFG, 8'h3c);
        repeat (3) @(negedge core_clk);
        chk_out(8'(n_pulse - n0), 8'h01);
        $display("test portcfg done");
        report_and_stop();
    end
endmodule // adc_config_register_bank_test
